/* design/usos_core.sv */
/*
 * Per-unit option store, selection policy, auto Request Sense launcher
 * and diagnostic gate of the adapter command processor, with APB regs.
 * Assumes the SCSI engine and command queue run on pclk (no synchroniser).
 */
// The APB interface to the registers and the register addresses were left to the implementer.
//
// Overview of operation
// RULE1 - Untagged flag 0 allows one command per target; 1 queues per LUN.
// RULE2 - Sync flag 1 starts sync negotiation; 0 never starts it.
// RULE3 - Negotiation begun by the peer is always answered.
// RULE4 - Wide flag 1 starts wide negotiation; 0 never starts it.
// RULE5 - Attention inhibit 1 keeps ATN off during selection; 0 asserts it.
// RULE6 - Attention inhibit blocks negotiations, parity; conflicting flags raise error.
// RULE7 - Initiator: tag 1 negotiates tagged queuing, 0 does not.
// RULE8 - Target: tag 0 accepts 6-byte group 2, tag 1 accepts 10-byte.
// RULE9 - Check Condition launches Request Sense unless inhibited per command; the code also drops it while the sense sequencer is busy.
// RULE10 - Sense count above 32 is forced to 8 with error A1H.
// RULE11 - Nonzero count fetches that many leading bytes, fields ignored.
// RULE12 - Eight 8-bit selection fields, used only when count is zero.
// RULE13 - Zero count and zero fields return bytes 0 to 7.
// RULE14 - Zero count with nonzero fields returns listed bytes in order.
// RULE15 - Unit options command decodes on code 08H.
// RULE16 - Diagnostic 09H runs selected tests and reports a result.
// RULE17 - Diagnostic waits until earlier commands have completed.
// RULE18 - No commands during diagnostic; pending attentions serviced afterwards.
// RULE19 - Tag flag set makes the untagged flag irrelevant.
// RULE20 - Flags: tag bit 6, wide 3, inhibit 2, sync 1, untagged 0.
// RULE21 - Separate options per unit, applied by addressed unit.
`timescale 1ns/1ps

module usos_core
	import usos_pkg::*;
#(
	parameter int UNITS = 16
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cmds_idle,
	input  wire logic        sel_start,
	input  wire logic [3:0]  sel_unit,
	input  wire logic        peer_neg,
	input  wire logic        check_cond,
	input  wire logic [3:0]  cc_unit,
	input  wire logic        request_sense_inhibit,
	input  wire logic        diag_done,
	output logic             atn_assert,
	output logic             sync_neg_start,
	output logic             wide_neg_start,
	output logic             tag_neg_start,
	output logic             parity_check,
	output logic             one_cmd_only,
	output logic             grp2_ten_byte,
	output logic             neg_reply,
	output logic             req_sense,
	output logic       [7:0] req_sense_len,
	output logic       [7:0] sense_byte,
	output logic             sense_byte_vld,
	output logic             diag_start,
	output logic             diag_running,
	output logic             attn_service
);

	// ==========================================================
	// Register file and per-unit store
	logic [31:0] unit_r;
	logic [31:0] sel_lo_r;
	logic [31:0] sel_hi_r;
	logic        target_mode_r;
	logic [7:0]  err_r;
	logic [7:0]  pend_cnt_r;
	logic [7:0]  pend_code_r;
	usos_state_t state_r;
	logic [7:0]  flags_mem [UNITS];
	logic [5:0]  scnt_mem  [UNITS];
	logic [63:0] sel_mem   [UNITS];
	logic        seq_busy;

	logic        acc;
	logic        wr_en;
	logic        cmd_wr;
	logic        exec_now;
	logic [7:0]  exec_code;
	logic [7:0]  in_flags;
	logic [7:0]  in_scnt;
	logic [3:0]  in_unit;
	logic [7:0]  sf;
	logic        atn_inh;

	assign acc       = psel && penable && pready;
	assign wr_en     = acc && pwrite && ce;
	assign cmd_wr    = wr_en && (paddr == USOS_OFF_CMD);
	assign in_unit   = unit_r[USOS_UNIT_LSB +: 4];
	assign in_flags  = unit_r[USOS_FLAGS_LSB +: 8] & USOS_FLG_MASK; // RULE20
	assign in_scnt   = unit_r[USOS_SCNT_LSB +: 8];
	// A command runs immediately only when no diagnostic owns the board
	assign exec_now  = (cmd_wr && state_r == USOS_IDLE)
	                 || (state_r == USOS_DRAIN && pend_cnt_r != '0);
	assign exec_code = (state_r == USOS_DRAIN) ? pend_code_r : pwdata[7:0];

	// ==========================================================
	// APB slave: zero wait, answer prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else if (ce) begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= '0;
			if (psel && !penable) begin
				unique case (paddr)
					USOS_OFF_CMD:    prdata <= {24'h00_0000, pend_code_r};
					USOS_OFF_UNIT:   prdata <= unit_r;
					USOS_OFF_SEL_LO: prdata <= sel_lo_r;
					USOS_OFF_SEL_HI: prdata <= sel_hi_r;
					USOS_OFF_STATUS: prdata <= {7'h00, seq_busy, pend_cnt_r,
						6'h00, state_r, err_r};
					USOS_OFF_CTRL:   prdata <= {31'h0000_0000, target_mode_r};
					default:         pslverr <= 1'b1;
				endcase
			end
		end
	end

	// Parameter staging registers written by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_r        <= '0;
			sel_lo_r      <= '0;
			sel_hi_r      <= '0;
			target_mode_r <= 1'b0;
		end else if (wr_en) begin
			if (paddr == USOS_OFF_UNIT)
				unit_r <= pwdata;
			if (paddr == USOS_OFF_SEL_LO)
				sel_lo_r <= pwdata;
			if (paddr == USOS_OFF_SEL_HI)
				sel_hi_r <= pwdata;
			if (paddr == USOS_OFF_CTRL)
				target_mode_r <= pwdata[0];
		end
	end

	// ==========================================================
	// Command execution: unit options store and error report
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_r <= USOS_ERR_NONE;
		end else if (ce && exec_now) begin
			if (exec_code == USOS_CMD_UNIT_OPT) begin // RULE15
				if (in_scnt > USOS_SCNT_MAX)
					err_r <= USOS_ERR_SCNT; // RULE10
				else if (in_flags[USOS_FLG_ATN_INH]
				    && (in_flags[USOS_FLG_SYNC]
				    || in_flags[USOS_FLG_WIDE] || in_flags[USOS_FLG_TAG]))
					err_r <= USOS_ERR_ATN_INH; // RULE6
				else
					err_r <= USOS_ERR_NONE;
			end else if (exec_code == USOS_CMD_DIAG) begin
				err_r <= USOS_ERR_NONE;
			end else begin
				err_r <= USOS_ERR_BADCMD;
			end
		end
	end

	// Per-unit copies; an oversize count is stored as the forced value
	always_ff @(posedge pclk) begin
		if (ce && exec_now && exec_code == USOS_CMD_UNIT_OPT) begin
			flags_mem[in_unit] <= in_flags; // RULE21
			scnt_mem[in_unit]  <= (in_scnt > USOS_SCNT_MAX)
				? USOS_SCNT_FORCED : in_scnt[5:0]; // RULE10
			sel_mem[in_unit]   <= {sel_hi_r, sel_lo_r};
		end
	end

	// ==========================================================
	// Diagnostic gate; attentions arriving meanwhile are counted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r      <= USOS_IDLE;
			diag_start   <= 1'b0;
			diag_running <= 1'b0;
		end else if (ce) begin
			diag_start <= 1'b0;
			unique case (state_r)
				USOS_IDLE: if (exec_now && exec_code == USOS_CMD_DIAG)
					state_r <= USOS_WAIT;
				USOS_WAIT: if (cmds_idle) begin // RULE17
					state_r      <= USOS_RUN;
					diag_start   <= 1'b1; // RULE16
					diag_running <= 1'b1;
				end
				USOS_RUN: if (diag_done) begin
					state_r      <= USOS_DRAIN;
					diag_running <= 1'b0;
				end
				// A write landing on the last step keeps the drain going
				USOS_DRAIN: if (pend_cnt_r <= 8'h01 && !cmd_wr)
					state_r <= USOS_IDLE;
			endcase
		end
	end

	// Pending attention count: a set and a drain step in one cycle cancel out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_cnt_r   <= '0;
			pend_code_r  <= '0;
			attn_service <= 1'b0;
		end else if (ce) begin
			// Every drain step is one serviced attention, even when a
			// new write refills the slot in the same cycle
			attn_service <= (state_r == USOS_DRAIN)
				&& (pend_cnt_r != '0); // RULE18
			if (cmd_wr && state_r != USOS_IDLE) begin
				// Only the newest code is kept; older ones are serviced
				// as repeats of it, a limit of the single holding slot
				pend_code_r <= pwdata[7:0]; // RULE18
				if (!(state_r == USOS_DRAIN && pend_cnt_r != '0)
				    && pend_cnt_r != 8'hFF)
					pend_cnt_r <= pend_cnt_r + 8'h01;
			end else if (state_r == USOS_DRAIN && pend_cnt_r != '0) begin
				pend_cnt_r <= pend_cnt_r - 8'h01;
			end
		end
	end

	// ==========================================================
	// Selection policy from the addressed unit's copy
	assign sf      = flags_mem[sel_unit]; // RULE21
	assign atn_inh = sf[USOS_FLG_ATN_INH];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			atn_assert     <= 1'b0;
			sync_neg_start <= 1'b0;
			wide_neg_start <= 1'b0;
			tag_neg_start  <= 1'b0;
			parity_check   <= 1'b0;
			one_cmd_only   <= 1'b1;
			grp2_ten_byte  <= 1'b0;
		end else if (ce && sel_start) begin
			atn_assert     <= !atn_inh; // RULE5
			sync_neg_start <= sf[USOS_FLG_SYNC] && !atn_inh; // RULE2 RULE6
			wide_neg_start <= sf[USOS_FLG_WIDE] && !atn_inh; // RULE4 RULE6
			tag_neg_start  <= sf[USOS_FLG_TAG] && !atn_inh
				&& !target_mode_r; // RULE7 RULE6
			parity_check   <= !atn_inh; // RULE6
			// Tag set overrides the untagged choice
			one_cmd_only   <= !sf[USOS_FLG_TAG]
				&& !sf[USOS_FLG_UNTAGGED]; // RULE1 RULE19
			grp2_ten_byte  <= sf[USOS_FLG_TAG] && target_mode_r; // RULE8
		end
	end

	// Peer-begun negotiation is answered whatever the flags say
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			neg_reply <= 1'b0;
		else if (ce)
			neg_reply <= peer_neg; // RULE3
	end

	// ==========================================================
	// Automatic Request Sense launch
	logic       rs_go;
	logic [5:0] rs_cnt;

	assign rs_go  = check_cond && !request_sense_inhibit && !seq_busy;
	assign rs_cnt = scnt_mem[cc_unit];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_sense     <= 1'b0;
			req_sense_len <= '0;
		end else if (ce) begin
			req_sense <= rs_go; // RULE9
			if (rs_go)
				req_sense_len <= {2'b00, (rs_cnt != '0)
					? rs_cnt : USOS_SEL_FIELDS}; // RULE11
		end
	end

	usos_sense_seq u_seq (
		.clk      (pclk),
		.rstn     (presetn),
		.ce       (ce),
		.start    (rs_go),
		.count    (rs_cnt),
		.sel      (sel_mem[cc_unit]),
		.byte_num (sense_byte),
		.byte_vld (sense_byte_vld),
		.busy     (seq_busy)
	);

	// ==========================================================
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	atn_policy_a: assert property (ce && sel_start && atn_inh // RULE5
		|=> !atn_assert && !parity_check && !sync_neg_start)
		else $error("ATN or negotiation with inhibit set");
	sync_policy_a: assert property (ce && sel_start && !atn_inh // RULE2
		|=> sync_neg_start == $past(sf[USOS_FLG_SYNC]))
		else $error("sync negotiation does not follow flag");
	wide_policy_a: assert property (ce && sel_start && !atn_inh // RULE4
		|=> wide_neg_start == $past(sf[USOS_FLG_WIDE]))
		else $error("wide negotiation does not follow flag");
	queue_policy_a: assert property (ce && sel_start // RULE19
		&& sf[USOS_FLG_TAG] |=> !one_cmd_only)
		else $error("untagged flag used while tag set");
	grp2_mode_a: assert property (ce && sel_start && target_mode_r // RULE8
		|=> grp2_ten_byte == $past(sf[USOS_FLG_TAG]))
		else $error("group 2 length does not follow tag");
	peer_reply_a: assert property (ce && peer_neg |=> neg_reply) // RULE3
		else $error("peer negotiation not answered");
	auto_sense_a: assert property (ce && check_cond // RULE9
		&& request_sense_inhibit |=> !req_sense)
		else $error("request sense issued while inhibited");
	scnt_clamp_a: assert property (ce && exec_now // RULE10
		&& exec_code == USOS_CMD_UNIT_OPT && in_scnt > USOS_SCNT_MAX
		|=> err_r == USOS_ERR_SCNT)
		else $error("oversize sense count not reported");
	diag_wait_a: assert property (diag_start // RULE17
		|-> $past(cmds_idle) && $past(state_r) == USOS_WAIT)
		else $error("diagnostic started with commands outstanding");
	diag_block_a: assert property (state_r == USOS_RUN // RULE18
		|=> err_r == $past(err_r))
		else $error("command executed during diagnostic");
	sense_len_a: assert property (ce && rs_go && rs_cnt == '0 // RULE13
		|=> req_sense_len == 8'h08)
		else $error("default sense length is not eight");

	diag_cycle_c: cover property (diag_start ##[1:50] attn_service);
	sense_seq_c:  cover property (req_sense ##[1:40] !seq_busy);
	scnt_err_c:   cover property (err_r == USOS_ERR_SCNT);
	atn_inh_sel_c: cover property (sel_start && atn_inh);

endmodule

/* shared/usos_pkg.sv */
/*
 * Package for the per-unit option store and sense selector: register map,
 * unit flag layout, command codes, error codes and sense-selection limits.
 * Assumes a 32-bit APB register bus and one clock domain.
 */
package usos_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] USOS_OFF_CMD    = 8'h00;
	localparam logic [7:0] USOS_OFF_UNIT   = 8'h04;
	localparam logic [7:0] USOS_OFF_SEL_LO = 8'h08;
	localparam logic [7:0] USOS_OFF_SEL_HI = 8'h0C;
	localparam logic [7:0] USOS_OFF_STATUS = 8'h10;
	localparam logic [7:0] USOS_OFF_CTRL   = 8'h14;

	// ==========================================================
	// Unit flags byte layout
	localparam int USOS_FLG_UNTAGGED = 0;
	localparam int USOS_FLG_SYNC     = 1;
	localparam int USOS_FLG_ATN_INH  = 2;
	localparam int USOS_FLG_WIDE     = 3;
	localparam int USOS_FLG_TAG      = 6;
	localparam logic [7:0] USOS_FLG_MASK = 8'h4F;

	// ==========================================================
	// UNIT register fields
	localparam int USOS_UNIT_LSB  = 0;
	localparam int USOS_FLAGS_LSB = 8;
	localparam int USOS_SCNT_LSB  = 16;

	// ==========================================================
	// STATUS register fields
	localparam int USOS_ST_ERR_LSB  = 0;
	localparam int USOS_ST_STATE    = 8;
	localparam int USOS_ST_PEND_LSB = 16;
	localparam int USOS_ST_SBUSY    = 24;

	// ==========================================================
	// Command and error codes
	localparam logic [7:0] USOS_CMD_UNIT_OPT = 8'h08;
	localparam logic [7:0] USOS_CMD_DIAG     = 8'h09;
	localparam logic [7:0] USOS_ERR_NONE     = 8'h00;
	localparam logic [7:0] USOS_ERR_SCNT     = 8'hA1;
	localparam logic [7:0] USOS_ERR_ATN_INH  = 8'hA2;
	localparam logic [7:0] USOS_ERR_BADCMD   = 8'hA3;

	// ==========================================================
	// Sense selection limits
	localparam logic [7:0] USOS_SCNT_MAX    = 8'h20;
	localparam logic [5:0] USOS_SCNT_FORCED = 6'h08;
	localparam logic [5:0] USOS_SEL_FIELDS  = 6'h08;
	localparam int         USOS_SEL_NUM     = 8;
	localparam logic [7:0] USOS_RESET_BYTE  = 8'h00;

	// ==========================================================
	// Command processor states, Gray along idle-wait-run-drain
	typedef enum logic [1:0] {
		USOS_IDLE  = 2'b00,
		USOS_WAIT  = 2'b01,
		USOS_RUN   = 2'b11,
		USOS_DRAIN = 2'b10
	} usos_state_t;

endpackage

/* design/usos_sense_seq.sv */
/*
 * Sense byte sequencer: on start, emits the sense byte numbers that an
 * automatic Request Sense should return, one per enabled clock.
 * Assumes start only while idle and count already limited to 0..32.
 */
`timescale 1ns/1ps

module usos_sense_seq
	import usos_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic        start,
	input  wire logic [5:0]  count,
	input  wire logic [63:0] sel,
	output logic       [7:0] byte_num,
	output logic             byte_vld,
	output logic             busy
);

	logic [5:0]  idx_r;
	logic [5:0]  total_r;
	logic        listed_r;
	logic [63:0] sel_r;
	logic [7:0]  pick;

	// Listed mode picks the idx-th selection field
	always_comb begin
		pick = sel_r[idx_r[2:0]*8 +: 8];
	end

	// Capture the plan at start, then walk it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			idx_r    <= '0;
			total_r  <= '0;
			listed_r <= 1'b0;
			sel_r    <= '0;
			busy     <= 1'b0;
			byte_vld <= 1'b0;
			byte_num <= USOS_RESET_BYTE;
		end else if (ce) begin
			byte_vld <= 1'b0;
			if (start && !busy) begin
				busy     <= 1'b1;
				idx_r    <= '0;
				sel_r    <= sel;
				// Nonzero count: leading bytes, fields ignored
				total_r  <= (count != '0) ? count : USOS_SEL_FIELDS; // RULE11
				// Fields only count when the count is zero
				listed_r <= (count == '0) && (sel != '0); // RULE12
			end else if (busy) begin
				byte_vld <= 1'b1;
				// Natural order by default, listed order otherwise
				byte_num <= listed_r ? pick : {2'b00, idx_r}; // RULE13 RULE14
				idx_r    <= idx_r + 6'd1;
				if (idx_r + 6'd1 == total_r)
					busy <= 1'b0;
			end
		end
	end

endmodule

/* tb/usos_periph_model.sv */
/*
 * Peripheral model on the far SCSI side: raises check conditions and
 * negotiation openings on request, and collects the sense byte numbers.
 * Assumes the single pclk domain and one-cycle request pulses.
 */
`timescale 1ns/1ps

module usos_periph_model
	import usos_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       cc_go,
	input  wire logic [3:0] go_unit,
	input  wire logic       neg_go,
	input  wire logic [7:0] sense_byte,
	input  wire logic       sense_byte_vld,
	output logic            check_cond,
	output logic      [3:0] cc_unit,
	output logic            peer_neg,
	output logic      [7:0] got [0:31],
	output int              got_n
);
	// ==========================================================
	// Requests; unit lines toggle when unqualified so a stale id shows only on every other cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			check_cond <= 1'b0;
			peer_neg   <= 1'b0;
			cc_unit    <= 4'h0;
		end else begin
			check_cond <= cc_go;
			peer_neg   <= neg_go;
			cc_unit    <= cc_go ? go_unit : ~cc_unit;
		end
	end

	// ==========================================================
	// Sense byte capture, restarted by each check condition
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			got_n <= 0;
		end else if (cc_go) begin
			got_n <= 0;
		end else if (sense_byte_vld && got_n < 32) begin
			got[got_n] <= sense_byte;
			got_n      <= got_n + 1;
		end
	end
endmodule

/* tb/scsi_unit_options_sense_select_tb.sv */
/*
 * Self-checking bench for the unit option store and sense selector.
 * Assumes the APB slave answers in a bounded time and a 250 MHz pclk.
 */
`timescale 1ns/1ps

module scsi_unit_options_sense_select_tb
	import usos_pkg::*;
;
	typedef struct packed {
		logic [7:0] fl;
		logic       tm;
		logic [6:0] ex;
		logic [7:0] er;
	} usos_row_t;

	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, req_sense_len, sense_byte;
	logic [31:0] pwdata, prdata, rd;
	logic        cmds_idle, sel_start, check_cond, diag_done, cc_go, slv;
	logic        neg_go, peer_neg, sense_byte_vld, neg_reply, req_sense;
	logic        request_sense_inhibit, seen;
	logic [3:0]  sel_unit, cc_unit, go_unit;
	logic        atn_assert, sync_neg_start, wide_neg_start, tag_neg_start;
	logic        parity_check, one_cmd_only, grp2_ten_byte;
	logic        diag_start, diag_running, attn_service;
	logic [6:0]  pol;
	logic [7:0]  got [0:31];
	logic [63:0] sbs;
	int          got_n, miscompares, cmp_count, n, attn_n, base;
	usos_row_t   rows [0:7];

	usos_core DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .cmds_idle, .sel_start,
		.sel_unit, .peer_neg, .check_cond, .cc_unit, .request_sense_inhibit,
		.diag_done, .atn_assert, .sync_neg_start, .wide_neg_start,
		.tag_neg_start, .parity_check, .one_cmd_only, .grp2_ten_byte,
		.neg_reply, .req_sense, .req_sense_len, .sense_byte,
		.sense_byte_vld, .diag_start, .diag_running, .attn_service);

	usos_periph_model PEER (.pclk, .presetn, .cc_go, .go_unit, .neg_go,
		.sense_byte, .sense_byte_vld, .check_cond, .cc_unit, .peer_neg,
		.got, .got_n);

	// Policy outputs gathered for table compares
	assign pol = {atn_assert, sync_neg_start, wide_neg_start,
		tag_neg_start, parity_check, one_cmd_only, grp2_ten_byte};

	// ==========================================================
	// Clock and attention pulse count
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (attn_service === 1'b1) attn_n++;
	end

	// ==========================================================
	// Compare, report and bus tasks
	task chk(input logic [31:0] got_v, input logic [31:0] exp_v);
		cmp_count++;
		if (got_v !== exp_v) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got_v, exp_v);
		end
	endtask

	task final_report;
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// A used-up wait bound is a mismatch and ends the run
	task tmo;
		chk(32'h0000_0000, 32'h0000_0001);
		final_report;
	endtask

	// Holds the request until pready is seen at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) tmo;
		rd  = prdata;
		slv = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Stores one unit's options, leaves the status word in rd
	task setunit(input logic [3:0] u, input logic [7:0] fl,
		input logic [7:0] cnt, input logic [63:0] s);
		apb(1'b1, USOS_OFF_SEL_LO, s[31:0]);
		apb(1'b1, USOS_OFF_SEL_HI, s[63:32]);
		apb(1'b1, USOS_OFF_UNIT, {8'h00, cnt, fl, 4'h0, u});
		apb(1'b1, USOS_OFF_CMD, {24'h00_0000, USOS_CMD_UNIT_OPT});
		apb(1'b0, USOS_OFF_STATUS, 32'h0000_0000);
	endtask

	// Outputs follow one edge after the selection pulse
	task selu(input logic [3:0] u);
		@(posedge pclk);
		sel_start <= 1'b1;
		sel_unit  <= u;
		@(posedge pclk);
		sel_start <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	task sense(input logic [3:0] u, input int cnt, input logic use_sel);
		int i;
		@(posedge pclk);
		cc_go   <= 1'b1;
		go_unit <= u;
		@(posedge pclk);
		cc_go   <= 1'b0;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (req_sense !== 1'b1 && i < 20);
		if (req_sense !== 1'b1) tmo;
		chk(req_sense_len, cnt);
		i = 0;
		while (got_n < cnt && i < 80) begin
			@(posedge pclk);
			i++;
		end
		repeat (4) @(posedge pclk);
		chk(got_n, cnt);
		for (i = 0; i < cnt; i++) begin
			chk(got[i], use_sel ? sbs[8*i +: 8] : i);
		end
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rows = '{'{8'h00, 1'b0, 7'b1000110, 8'h00},
			'{8'hB1, 1'b0, 7'b1000100, 8'h00},
			'{8'h02, 1'b0, 7'b1100110, 8'h00},
			'{8'h08, 1'b0, 7'b1010110, 8'h00},
			'{8'h40, 1'b0, 7'b1001100, 8'h00},
			'{8'h41, 1'b1, 7'b1000101, 8'h00},
			'{8'h04, 1'b0, 7'b0000010, 8'h00},
			'{8'h06, 1'b0, 7'b0000010, 8'hA2}};
		{ce, presetn, psel, penable, pwrite, cmds_idle, sel_start} = 7'h42;
		{diag_done, cc_go, neg_go, request_sense_inhibit} = 4'h0;
		{paddr, pwdata, sel_unit, go_unit} = 48'h0;
		{miscompares, cmp_count, attn_n} = 0;
		sbs = 64'h1011_0F0C_0302_0100;
		repeat (5) @(posedge pclk);
		chk({pready, pslverr, req_sense, one_cmd_only, atn_assert}, 5'h02);
		presetn <= 1'b1;
		$display("reset test done");
		// Flag table, one unit per row
		for (n = 0; n < 8; n++) begin
			apb(1'b1, USOS_OFF_CTRL, {31'h0, rows[n].tm});
			setunit(n[3:0], rows[n].fl, 8'h00, 64'h0);
			chk(rd[7:0], rows[n].er);
			selu(n[3:0]);
			chk(pol, rows[n].ex);
		end
		apb(1'b1, USOS_OFF_CTRL, 32'h0000_0000);
		selu(4'h0);
		chk(pol, rows[0].ex);
		// Enable low: a selection of another unit must change nothing
		ce <= 1'b0;
		selu(4'h7);
		chk(pol, rows[0].ex);
		ce <= 1'b1;
		@(posedge pclk);
		neg_go <= 1'b1;
		@(posedge pclk);
		neg_go <= 1'b0;
		seen = 1'b0;
		repeat (4) begin
			@(posedge pclk);
			if (neg_reply === 1'b1) seen = 1'b1;
		end
		chk(seen, 1'b1);
		$display("unit flag table done");
		// Sense count and selection
		setunit(4'h9, 8'h00, 8'h21, 64'h0);
		chk(rd[7:0], USOS_ERR_SCNT);
		sense(4'h9, 8, 1'b0);
		setunit(4'h9, 8'h00, 8'h20, sbs);
		chk(rd[7:0], USOS_ERR_NONE);
		sense(4'h9, 32, 1'b0);
		setunit(4'hA, 8'h00, 8'h00, 64'h0);
		sense(4'hA, 8, 1'b0);
		setunit(4'hB, 8'h00, 8'h00, sbs);
		setunit(4'hC, 8'h00, 8'h05, sbs);
		sense(4'hC, 5, 1'b0);
		sense(4'hB, 8, 1'b1);
		request_sense_inhibit <= 1'b1;
		cc_go   <= 1'b1;
		go_unit <= 4'hB;
		@(posedge pclk);
		cc_go   <= 1'b0;
		seen = 1'b0;
		repeat (10) begin
			@(posedge pclk);
			if (req_sense === 1'b1) seen = 1'b1;
		end
		chk(seen, 1'b0);
		request_sense_inhibit <= 1'b0;
		$display("sense test done");
		// Unmapped place and unknown code
		apb(1'b0, 8'h18, 32'hFFFF_FFFF);
		chk(slv, 1'b1);
		chk(rd, 32'h0000_0000);
		apb(1'b1, USOS_OFF_CMD, 32'h0000_0007);
		apb(1'b0, USOS_OFF_STATUS, 32'h0000_0000);
		chk(rd[7:0], USOS_ERR_BADCMD);
		$display("refusal test done");
		// Diagnostic held back by busy commands, pending work afterwards
		cmds_idle <= 1'b0;
		base = attn_n;
		apb(1'b1, USOS_OFF_CMD, {24'h00_0000, USOS_CMD_DIAG});
		apb(1'b1, USOS_OFF_CMD, {24'h00_0000, USOS_CMD_UNIT_OPT});
		apb(1'b0, USOS_OFF_STATUS, 32'h0000_0000);
		chk(rd[9:8], 2'b01);
		chk(attn_n - base, 0);
		cmds_idle <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (diag_start !== 1'b1 && n < 20);
		if (diag_start !== 1'b1) tmo;
		@(posedge pclk);
		chk(diag_running, 1'b1);
		apb(1'b1, USOS_OFF_CMD, {24'h00_0000, USOS_CMD_UNIT_OPT});
		chk(attn_n - base, 0);
		diag_done <= 1'b1;
		@(posedge pclk);
		diag_done <= 1'b0;
		n = 0;
		while (attn_n - base < 2 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		repeat (4) @(posedge pclk);
		chk(attn_n - base, 2);
		chk(diag_running, 1'b0);
		$display("diagnostic test done");
		final_report;
	end
endmodule
